// File: shared/scc_regs.svh
// register map, timing counts and the behavioural overview of the stepper current chopper
// Overview of operation
// - mode pins set microstep size per step
// - fixed PWM period starts each drive phase
// - after trip, decay until period ends
// - trip ignored during blanking at drive start
// - full-scale setting caps every trip threshold
// - direct mode: phase input sets coil direction
// - decay pin low slow, high fast, floating mixed
// - over-temperature disables outputs until it clears
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH

// timing
`define SCC_CLK_PERIOD_NS 50
`define SCC_PWM_PERIOD_NS 50000
`define SCC_PWM_PERIOD_CYC ((`SCC_PWM_PERIOD_NS) / (`SCC_CLK_PERIOD_NS))
`define SCC_BLANK_NS 2000
`define SCC_BLANK_CYC (((`SCC_BLANK_NS) + (`SCC_CLK_PERIOD_NS) - 1) / (`SCC_CLK_PERIOD_NS))

// byte offsets on the register bus
`define SCC_OFF_CTRL 5'h00
`define SCC_OFF_FULL_SCALE 5'h04
`define SCC_OFF_REF_A 5'h08
`define SCC_OFF_REF_B 5'h0C
`define SCC_OFF_STATUS 5'h10

// control fields and reset values
`define SCC_CTRL_ENABLE 0
`define SCC_CTRL_INDEXER 1
`define SCC_CTRL_RST 2'h0
`define SCC_FULL_SCALE_RST 8'hFF
`define SCC_REF_RST 8'h00

// status fields
`define SCC_ST_SHUTOFF 0
`define SCC_ST_INDEXER 1
`define SCC_ST_DRIVE_A 2
`define SCC_ST_DRIVE_B 3
`define SCC_ST_INDEX_LSB 8

// indexer: 128 positions per electrical turn, 32 per quarter
`define SCC_INDEX_RST 7'h10
`define SCC_FULL_STEP 7'h20
`define SCC_RES_MAX 3'h5
`define SCC_QTR_POS 7'h20
`define SCC_QTR_LVL 6'h20

`endif

// File: shared/scc_pkg.sv
// types shared by the stepper current chopper design
package scc_pkg;

   typedef enum logic [1:0] {
      SCC_DECAY_SLOW,
      SCC_DECAY_FAST,
      SCC_DECAY_MIXED
   } scc_decay_e;

   typedef enum logic [1:0] {
      SCC_CH_OFF,
      SCC_CH_BLANK,
      SCC_CH_DRIVE,
      SCC_CH_DECAY
   } scc_chop_e;

   // index 0 is coil A, index 1 is coil B
   typedef struct packed {
      logic step;
      logic dir;
      logic [2:0] res_sel;
      logic [1:0] phase;
      logic [1:0] decay_select_level;
      logic [1:0] decay_select_driven;
      logic [1:0] trip;
      logic over_temperature_shutoff;
   } scc_pins_s;

   typedef struct packed {
      logic enable;
      logic drive;
      logic dir;
      scc_decay_e decay;
      logic [7:0] trip_threshold;
   } scc_coil_s;

endpackage

// File: rtl/scc_chopper.sv
// per-coil fixed-period current chopper with blanking
`include "scc_regs.svh"

module scc_chopper #(
   parameter int unsigned BLANK_CYC = `SCC_BLANK_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic run_i,
   input wire logic period_start_i,
   input wire logic trip_i,
   output scc_pkg::scc_chop_e state_o,
   output logic drive_o
);

   scc_pkg::scc_chop_e state_q, state_d;
   logic [15:0] blank_q, blank_d;

   always_comb begin
      state_d = state_q;
      blank_d = blank_q;
      if (!run_i) begin
         state_d = scc_pkg::SCC_CH_OFF;
      end else if (period_start_i) begin
         state_d = scc_pkg::SCC_CH_BLANK;
         blank_d = 16'(BLANK_CYC - 1);
      end else begin
         unique case (state_q)
            scc_pkg::SCC_CH_OFF: begin
            end
            scc_pkg::SCC_CH_BLANK: begin
               // comparator not looked at here: overshoot is accepted
               if (blank_q == 16'h0000) begin
                  state_d = scc_pkg::SCC_CH_DRIVE;
               end else begin
                  blank_d = blank_q - 16'h0001;
               end
            end
            scc_pkg::SCC_CH_DRIVE: begin
               if (trip_i) begin
                  state_d = scc_pkg::SCC_CH_DECAY;
               end
            end
            scc_pkg::SCC_CH_DECAY: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q <= scc_pkg::SCC_CH_OFF;
         blank_q <= 16'h0000;
      end else begin
         state_q <= state_d;
         blank_q <= blank_d;
      end
   end

   assign state_o = state_q;
   assign drive_o = (state_q == scc_pkg::SCC_CH_BLANK) || (state_q == scc_pkg::SCC_CH_DRIVE);

   // consecutive drive cycles since blanking began, read only by the checks
   logic [15:0] drv_run_q, drv_run_d;
   always_comb begin
      drv_run_d = drive_o ? drv_run_q + 16'h0001 : 16'h0000;
      if (state_q == scc_pkg::SCC_CH_BLANK && blank_q == 16'(BLANK_CYC - 1)) begin
         drv_run_d = 16'h0001;
      end
   end
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         drv_run_q <= 16'h0000;
      end else begin
         drv_run_q <= drv_run_d;
      end
   end

   a_blank_min_drive: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (state_q == scc_pkg::SCC_CH_DECAY && $past(state_q) == scc_pkg::SCC_CH_DRIVE)
      |-> $past(drv_run_q) >= 16'(BLANK_CYC))
      else $error("decay entered before blanking interval ended");

   a_period_restart: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (run_i && period_start_i)
      |=> state_q == scc_pkg::SCC_CH_BLANK ##1 (drive_o || !$past(run_i)))
      else $error("period start did not begin a drive phase");

   a_trip_holds_decay: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (((state_q == scc_pkg::SCC_CH_DRIVE && trip_i) || state_q == scc_pkg::SCC_CH_DECAY)
      && run_i && !period_start_i)
      |=> state_q == scc_pkg::SCC_CH_DECAY)
      else $error("trip did not hold decay until period end");

endmodule // scc_chopper

// File: rtl/scc_top.sv
// stepper current chopper: indexer, pwm chopping per coil, thermal cut-off, avalon-mm registers
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`include "scc_regs.svh"

module scc_top #(
   parameter int unsigned PWM_PERIOD_CYC = `SCC_PWM_PERIOD_CYC,
   parameter int unsigned BLANK_CYC = `SCC_BLANK_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire scc_pkg::scc_pins_s pins_i,
   output scc_pkg::scc_coil_s coil_a_o,
   output scc_pkg::scc_coil_s coil_b_o
);

   localparam logic [7:0] SINE_TBL [0:32] = '{
      8'h00, 8'h0D, 8'h19, 8'h25, 8'h32, 8'h3E, 8'h4A, 8'h56,
      8'h62, 8'h6D, 8'h78, 8'h83, 8'h8E, 8'h98, 8'hA2, 8'hAB,
      8'hB4, 8'hBD, 8'hC5, 8'hCD, 8'hD4, 8'hDB, 8'hE1, 8'hE7,
      8'hEC, 8'hF0, 8'hF4, 8'hF7, 8'hFA, 8'hFC, 8'hFE, 8'hFF,
      8'hFF
   };

   function automatic logic [7:0] sine_level(input logic [6:0] pos);
      logic [5:0] q;
      q = {1'b0, pos[4:0]};
      if (pos[5]) begin
         q = `SCC_QTR_LVL - q;
      end
      return SINE_TBL[q];
   endfunction

   // pin synchroniser: stage one is read only by stage two
   scc_pkg::scc_pins_s pins_m_q, pins_s_q, step_prev_q;
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pins_m_q <= '0;
         pins_s_q <= '0;
         step_prev_q <= '0;
      end else begin
         pins_m_q <= pins_i;
         pins_s_q <= pins_m_q;
         step_prev_q <= pins_s_q;
      end
   end

   // registers
   logic [1:0] ctrl_q, ctrl_d;
   logic [7:0] fs_q, fs_d;
   logic [7:0] ref_q [2];
   logic [7:0] ref_d [2];
   logic ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   logic [31:0] status;
   logic bus_req, wr_commit;

   logic run, indexer, shutoff;
   logic [1:0] chop_drive;

   assign shutoff = pins_s_q.over_temperature_shutoff;
   assign indexer = ctrl_q[`SCC_CTRL_INDEXER];
   assign run = ctrl_q[`SCC_CTRL_ENABLE] && !shutoff;

   // one wait cycle per access; commit on the edge where waitrequest is low
   assign bus_req = avs_read_i || avs_write_i;
   assign avs_waitrequest_o = bus_req && !ack_q;
   assign wr_commit = avs_write_i && ack_q && avs_byteenable_i[0];

   logic [6:0] idx_q, idx_d;
   assign status = {16'h0000, 1'b0, idx_q, 4'h0,
      chop_drive[1], chop_drive[0], indexer, shutoff};

   always_comb begin
      ack_d = bus_req && !ack_q;
      ctrl_d = ctrl_q;
      fs_d = fs_q;
      ref_d = ref_q;
      rdata_d = rdata_q;
      if (wr_commit) begin
         case (avs_address_i)
            `SCC_OFF_CTRL: ctrl_d = avs_writedata_i[1:0];
            `SCC_OFF_FULL_SCALE: fs_d = avs_writedata_i[7:0];
            `SCC_OFF_REF_A: ref_d[0] = avs_writedata_i[7:0];
            `SCC_OFF_REF_B: ref_d[1] = avs_writedata_i[7:0];
            default: begin
            end
         endcase
      end
      if (avs_read_i && !ack_q) begin
         case (avs_address_i)
            `SCC_OFF_CTRL: rdata_d = {30'h0, ctrl_q};
            `SCC_OFF_FULL_SCALE: rdata_d = {24'h0, fs_q};
            `SCC_OFF_REF_A: rdata_d = {24'h0, ref_q[0]};
            `SCC_OFF_REF_B: rdata_d = {24'h0, ref_q[1]};
            `SCC_OFF_STATUS: rdata_d = status;
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_q <= 1'b0;
         ctrl_q <= `SCC_CTRL_RST;
         fs_q <= `SCC_FULL_SCALE_RST;
         ref_q[0] <= `SCC_REF_RST;
         ref_q[1] <= `SCC_REF_RST;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q <= ack_d;
         ctrl_q <= ctrl_d;
         fs_q <= fs_d;
         ref_q <= ref_d;
         rdata_q <= rdata_d;
      end
   end

   assign avs_readdata_o = rdata_q;

   // indexer
   logic [2:0] res;
   logic [6:0] step_size;
   logic step_rise;
   assign res = (pins_s_q.res_sel > `SCC_RES_MAX) ? `SCC_RES_MAX : pins_s_q.res_sel;
   assign step_size = `SCC_FULL_STEP >> res;
   assign step_rise = pins_s_q.step && !step_prev_q.step;

   always_comb begin
      idx_d = idx_q;
      if (step_rise && indexer && run) begin
         idx_d = pins_s_q.dir ? idx_q + step_size : idx_q - step_size;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         idx_q <= `SCC_INDEX_RST;
      end else begin
         idx_q <= idx_d;
      end
   end

   // pwm period timer shared by both coils
   logic [15:0] per_q, per_d;
   logic period_start;
   assign period_start = (per_q == 16'h0000);
   always_comb begin
      per_d = (per_q == 16'(PWM_PERIOD_CYC - 1)) ? 16'h0000 : per_q + 16'h0001;
   end
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         per_q <= 16'h0000;
      end else begin
         per_q <= per_d;
      end
   end

   for (genvar g = 0; g < 2; g++) begin : g_coil
      scc_chopper #(
         .BLANK_CYC(BLANK_CYC)
      ) u_chop (
         .sys_clk_i(sys_clk_i),
         .rstn_i(rstn_i),
         .run_i(run),
         .period_start_i(period_start),
         .trip_i(pins_s_q.trip[g]),
         .state_o(),
         .drive_o(chop_drive[g])
      );
   end

   // coil outputs
   scc_pkg::scc_coil_s coil_q [2];
   scc_pkg::scc_coil_s coil_d [2];
   logic [6:0] pos [2];
   logic [7:0] level [2];
   logic [15:0] prod [2];

   always_comb begin
      pos[0] = idx_q;
      pos[1] = idx_q + `SCC_QTR_POS;
      for (int i = 0; i < 2; i++) begin
         // one scaling path: the trip threshold never exceeds full scale
         level[i] = indexer ? sine_level(pos[i]) : ref_q[i];
         prod[i] = fs_q * level[i];
         coil_d[i].trip_threshold = prod[i][15:8];
         coil_d[i].enable = run;
         coil_d[i].drive = run && chop_drive[i];
         coil_d[i].dir = indexer ? !pos[i][6] : pins_s_q.phase[i];
         if (!pins_s_q.decay_select_driven[i]) begin
            coil_d[i].decay = scc_pkg::SCC_DECAY_MIXED;
         end else if (pins_s_q.decay_select_level[i]) begin
            coil_d[i].decay = scc_pkg::SCC_DECAY_FAST;
         end else begin
            coil_d[i].decay = scc_pkg::SCC_DECAY_SLOW;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         coil_q[0] <= '{1'b0, 1'b0, 1'b0, scc_pkg::SCC_DECAY_SLOW, 8'h00};
         coil_q[1] <= '{1'b0, 1'b0, 1'b0, scc_pkg::SCC_DECAY_SLOW, 8'h00};
      end else begin
         coil_q <= coil_d;
      end
   end

   assign coil_a_o = coil_q[0];
   assign coil_b_o = coil_q[1];

   a_shutoff_disables: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      shutoff |=> !coil_a_o.enable && !coil_b_o.enable && !coil_a_o.drive && !coil_b_o.drive)
      else $error("outputs active during over-temperature");

   a_shutoff_release: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      ($fell(shutoff) && ctrl_q[`SCC_CTRL_ENABLE]) |=> coil_a_o.enable)
      else $error("outputs not re-enabled after over-temperature cleared");

   a_step_advance: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (step_rise && indexer && run && pins_s_q.dir) |=> idx_q == $past(idx_q) + $past(step_size))
      else $error("index did not advance by one microstep");

   a_phase_sets_dir: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      !indexer |=> coil_b_o.dir == $past(pins_s_q.phase[1]))
      else $error("coil direction does not follow phase input");

   a_decay_mixed_float: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (!pins_s_q.decay_select_driven[0]) |=> coil_a_o.decay == scc_pkg::SCC_DECAY_MIXED)
      else $error("floating decay select did not give mixed decay");

   a_decay_fast_high: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (pins_s_q.decay_select_driven[1] && pins_s_q.decay_select_level[1])
      |=> coil_b_o.decay == scc_pkg::SCC_DECAY_FAST)
      else $error("high decay select did not give fast decay");

   a_full_scale_cap: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      ##1 (coil_a_o.trip_threshold <= $past(fs_q) && coil_b_o.trip_threshold <= $past(fs_q)))
      else $error("trip threshold above full-scale setting");

   a_bus_one_wait: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      ($rose(bus_req) || (bus_req && $past(ack_q))) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("bus access not answered after one wait cycle");

endmodule // scc_top

// File: tb/scc_ctrl_model.sv
// behavioural controller that drives the pin side of the chopper
module scc_ctrl_model (
   input wire logic sys_clk_i,
   output scc_pkg::scc_pins_s pins_o
);
   timeunit 1ns;
   timeprecision 1ps;
   scc_pkg::scc_pins_s cfg_q = '0;
   logic step_q = 1'b0;
   logic tg_q = 1'b0;
   // a floating decay pin wanders, so the model never lets it settle
   always @(posedge sys_clk_i) begin
      tg_q <= ~tg_q;
   end
   always_comb begin
      pins_o = cfg_q;
      pins_o.step = step_q;
      pins_o.decay_select_level = (cfg_q.decay_select_driven & cfg_q.decay_select_level) |
         (~cfg_q.decay_select_driven & {2{tg_q}});
   end
   task automatic cfg(input scc_pkg::scc_pins_s p);
      @(posedge sys_clk_i);
      cfg_q <= p;
   endtask
   // steady square wave, held low between bursts
   task automatic steps(input int n, input int half);
      repeat (n) begin
         @(posedge sys_clk_i);
         step_q <= 1'b1;
         repeat (half) @(posedge sys_clk_i);
         step_q <= 1'b0;
         repeat (half - 1) @(posedge sys_clk_i);
      end
   endtask
endmodule // scc_ctrl_model

// File: tb/testbench.sv
// self-checking bench for the stepper current chopper
`include "scc_regs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int P = 100;
   localparam int B = 4;
   logic sys_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [4:0] adr = 5'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [3:0] be = 4'hF;
   logic [31:0] rdata;
   logic wait_r;
   logic [31:0] q;
   scc_pkg::scc_pins_s pins;
   scc_pkg::scc_pins_s pc = '0;
   scc_pkg::scc_coil_s ca;
   scc_pkg::scc_coil_s cb;
   int fail_count = 0;
   int cmp_count = 0;
   int hi, per, n, k, lo, e;
   logic [7:0] fs, ra, rb;
   logic [6:0] old, stp, pb;

   initial begin
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   scc_top #(.PWM_PERIOD_CYC(P), .BLANK_CYC(B)) i_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_r),
      .pins_i(pins), .coil_a_o(ca), .coil_b_o(cb));
   scc_ctrl_model i_ctrl (.sys_clk_i(sys_clk_i), .pins_o(pins));

   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
         input logic [3:0] e);
      @(posedge sys_clk_i);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      be <= e;
      // request held until the edge that sees waitrequest low; only the watchdog ends a hang
      do begin
         @(posedge sys_clk_i);
      end while (wait_r !== 1'b0);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic rreg(input logic [4:0] a);
      bus(1'b0, a, 32'h0, 4'hF);
   endtask
   task automatic wreg(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   function automatic logic [7:0] thr(input logic [7:0] f, input logic [7:0] r);
      logic [15:0] p;
      p = f * r;
      return p[15:8];
   endfunction
   // high time and rise-to-rise spacing of coil a's drive
   task automatic meas(output int h, output int p);
      int c;
      c = 0;
      h = 0;
      while (ca.drive !== 1'b0 && c < 400) begin @(negedge sys_clk_i); c++; end
      while (ca.drive !== 1'b1 && c < 400) begin @(negedge sys_clk_i); c++; end
      while (ca.drive === 1'b1 && c < 400) begin @(negedge sys_clk_i); c++; h++; end
      p = h;
      while (ca.drive !== 1'b1 && c < 400) begin @(negedge sys_clk_i); c++; p++; end
      if (c >= 400) fail_count++;
   endtask
   // magnitude of a coil's level at an index, 255 at the crest
   function automatic int lvl(input logic [6:0] p);
      return int'(255.0 * $sin(3.14159265358979 * p[5:0] / 64.0));
   endfunction
   task test_done;
      if (fail_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk_i);
      fail_count++;
      test_done;
   end

   initial begin
      void'($urandom(32'h9f1d9e91));
      pc.decay_select_driven = 2'b11;
      i_ctrl.cfg(pc);
      repeat (12) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      rreg(`SCC_OFF_CTRL); chk(q, 32'h0);
      rreg(`SCC_OFF_FULL_SCALE); chk(q, 32'hFF);
      rreg(`SCC_OFF_REF_B); chk(q, 32'h0);
      rreg(`SCC_OFF_STATUS); chk(q, 32'h1000);
      rreg(5'h14); chk(q, 32'h0);
      bus(1'b1, `SCC_OFF_FULL_SCALE, 32'h12, 4'h0);
      wreg(`SCC_OFF_STATUS, 32'hFFFF);
      rreg(`SCC_OFF_FULL_SCALE); chk(q, 32'hFF);
      rreg(`SCC_OFF_STATUS); chk(q, 32'h1000);
      // direct phase mode with random scale, references and phases
      wreg(`SCC_OFF_CTRL, 32'h1);
      for (k = 0; k < 5; k++) begin
         fs = (k == 0) ? 8'hFF : 8'($urandom);
         ra = (k == 0) ? 8'hFF : 8'($urandom);
         rb = 8'($urandom);
         pc.phase = 2'($urandom);
         i_ctrl.cfg(pc);
         wreg(`SCC_OFF_FULL_SCALE, {24'h0, fs});
         wreg(`SCC_OFF_REF_A, {24'h0, ra});
         wreg(`SCC_OFF_REF_B, {24'h0, rb});
         repeat (8) @(posedge sys_clk_i);
         chk({24'h0, ca.trip_threshold}, {24'h0, thr(fs, ra)});
         chk({24'h0, cb.trip_threshold}, {24'h0, thr(fs, rb)});
         chk({30'h0, ca.dir, cb.dir}, {30'h0, pc.phase[0], pc.phase[1]});
      end
      // every decay selection on each coil, coils differing
      for (k = 0; k < 3; k++) begin
         pc.decay_select_level = {((k + 1) % 3) == 1, k == 1};
         pc.decay_select_driven = {((k + 1) % 3) != 2, k != 2};
         i_ctrl.cfg(pc);
         repeat (6) @(posedge sys_clk_i);
         chk({30'h0, ca.decay}, k);
         chk({30'h0, cb.decay}, (k + 1) % 3);
      end
      // trip held on coil a, coil b never trips
      pc.trip = 2'b01;
      i_ctrl.cfg(pc);
      repeat (2) begin
         meas(hi, per);
         chk(hi >= B && hi <= B + 3, 32'h1);
         chk(per, P);
      end
      lo = 0;
      repeat (2 * P) begin
         @(negedge sys_clk_i);
         lo += (cb.drive !== 1'b1);
      end
      chk(lo, 0);
      // indexer across every resolution code
      pc.trip = 2'b00;
      wreg(`SCC_OFF_CTRL, 32'h3);
      for (k = 0; k < 8; k++) begin
         rreg(`SCC_OFF_STATUS);
         old = q[14:8];
         pc.res_sel = 3'(k);
         pc.dir = 1'($urandom);
         i_ctrl.cfg(pc);
         repeat (4) @(posedge sys_clk_i);
         n = 1 + $urandom % 6;
         i_ctrl.steps(n, 3);
         repeat (8) @(posedge sys_clk_i);
         stp = (k >= 5) ? 7'h01 : 7'(7'h20 >> k);
         rreg(`SCC_OFF_STATUS);
         chk(q[14:8], pc.dir ? 7'(old + n * stp) : 7'(old - n * stp));
         chk(q[1], 1'b1);
         pb = 7'(q[14:8] + 7'h20);
         e = int'(thr(fs, 8'(lvl(q[14:8]))));
         chk(ca.trip_threshold + 1 >= e && ca.trip_threshold <= e + 1, 1'b1);
         e = int'(thr(fs, 8'(lvl(pb))));
         chk(cb.trip_threshold + 1 >= e && cb.trip_threshold <= e + 1, 1'b1);
         chk({ca.dir, cb.dir}, {!q[14], !pb[6]});
      end
      // over-temperature stops drive and stepping until it clears
      pc.over_temperature_shutoff = 1'b1;
      i_ctrl.cfg(pc);
      repeat (8) @(posedge sys_clk_i);
      chk({ca.enable, cb.enable, ca.drive, cb.drive}, 4'h0);
      rreg(`SCC_OFF_STATUS);
      old = q[14:8];
      i_ctrl.steps(2, 3);
      repeat (8) @(posedge sys_clk_i);
      rreg(`SCC_OFF_STATUS);
      chk({q[14:8], q[0]}, {old, 1'b1});
      pc.over_temperature_shutoff = 1'b0;
      i_ctrl.cfg(pc);
      repeat (8) @(posedge sys_clk_i);
      chk({ca.enable, cb.enable}, 2'b11);
      test_done;
   end
endmodule // testbench
